/* File: ptpa_port.sv */
// pass-through add-on port in passive mode, with its phase fifo
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - status outputs update on the edge after a region hit is taken
// - burst flag low for multi-phase accesses, high for single phase
// - two-bit region number of the pending access
// - direction flag high for writes, low for reads
// - active-low byte enables of the current phase, zero means all valid
// - address strobe puts captured address on the data bus at once
// - sampled write strobe latches data; ready on last phase ends access
// - byte enables show outstanding bytes one clock after a transfer
// - a new access may start the clock after pending is released
// - captured address advances one word per completed data phase
// - with write fifo off, one word accepted until add-on consumes it
// - with write fifo off, burst flag is never asserted for writes
// - ready held low moves one word per clock, one per two clocks with write fifo off
// - data-port reads drive the bus one clock after being sampled
// - a sampled ready with a phase queued loads byte enables of the next phase, all ones after the last
// - burst flag released when one phase remains, pending kept
// - a held read strobe keeps driving data, byte enables move early

// ----------------------------------------------------------------
// phase fifo
// ----------------------------------------------------------------
module ptpa_fifo
  import ptpa_pkg::*;
#(
  parameter int WIDTH = ENT_W,
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             ahead_valid,
  output var  logic [WIDTH-1:0] ahead_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    nxt_wp;
  logic [AW-1:0]    rp_ff;
  logic [AW-1:0]    nxt_rp;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             push;
  logic             pop;

  always_comb
  begin
    push    = in_valid && (cnt_ff != CNT_FULL);
    pop     = out_ready && (cnt_ff != '0);
    nxt_wp  = push ? ((wp_ff == PTR_LAST) ? '0 : wp_ff + 1'b1) : wp_ff;
    nxt_rp  = pop ? ((rp_ff == PTR_LAST) ? '0 : rp_ff + 1'b1) : rp_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop)
    begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_cnt = cnt_ff - 1'b1;
    end
    in_ready  = (cnt_ff != CNT_FULL);
    out_valid = (cnt_ff != '0);
    out_data  = mem_ff[rp_ff];
    // head as it stands after this edge; an empty store bypasses the push
    ahead_valid = 1'b0;
    ahead_data  = mem_ff[nxt_rp];
    if (pop ? (cnt_ff > CNT_ONE) : (cnt_ff != '0))
    begin
      ahead_valid = 1'b1;
    end
    else if (push)
    begin
      ahead_valid = 1'b1;
      ahead_data  = in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage carries no reset, so no wide reset tree
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_ff[wp_ff] <= in_data;
    end
  end
endmodule

// ----------------------------------------------------------------
// add-on port
// ----------------------------------------------------------------
module ptpa_port
  import ptpa_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic                CLOCK,
  input  wire logic                RST_B,
  input  wire logic                PCI_HIT,
  input  wire logic                PCI_WRITE,
  input  wire logic                PCI_BURST,
  input  wire logic [REGION_W-1:0] PCI_REGION,
  input  wire logic [31:0]         PCI_ADDR,
  input  wire logic                WFIFO_BURST_EN,
  output var  logic                PCI_BUSY,
  input  wire logic                PCI_PH_VALID,
  output var  logic                PCI_PH_READY,
  input  wire logic [DATA_W-1:0]   PCI_PH_DATA,
  input  wire logic [BE_W-1:0]     PCI_PH_BE_N,
  input  wire logic                PCI_PH_LAST,
  output var  logic                PCI_RD_VALID,
  output var  logic [DATA_W-1:0]   PCI_RD_DATA,
  output var  logic [BE_W-1:0]     PCI_RD_BE_N,
  input  wire logic                SELECT_N,
  input  wire logic [PORT_ADR_MSB:PORT_ADR_LSB] ADR,
  input  wire logic [BE_W-1:0]     PORT_BYTE_ENABLES_N,
  input  wire logic                RD_N,
  input  wire logic                WR_N,
  input  wire logic                CAPTURE_ADDR_STROBE_N,
  input  wire logic                ADDON_READY_N,
  input  wire logic [DATA_W-1:0]   DQ_IN,
  output var  logic [DATA_W-1:0]   DQ_OUT,
  output var  logic                DQ_OE,
  output var  logic                ACCESS_PENDING_N,
  output var  logic                MULTI_PHASE_N,
  output var  logic [REGION_W-1:0] REGION_NUMBER,
  output var  logic                DIRECTION_IS_WRITE,
  output var  logic [BE_W-1:0]     PENDING_BYTE_ENABLES_N
);
  localparam logic [PORT_ADR_MSB:PORT_ADR_LSB] PORT_SEL =
    PASSTHRU_DATA_PORT_OFS[PORT_ADR_MSB:PORT_ADR_LSB];

  ptpa_state_t         state_ff;
  ptpa_state_t         nxt_state;
  logic [31:0]         captured_address_reg_ff;
  logic [31:0]         nxt_captured_address_reg;
  logic [REGION_W-1:0] region_ff;
  logic [REGION_W-1:0] nxt_region;
  logic                write_ff;
  logic                nxt_write;
  logic                burst_ff;
  logic                nxt_burst;
  logic [BE_W-1:0]     done_ff;
  logic [BE_W-1:0]     nxt_done;
  logic                pend_n_ff;
  logic                multi_n_ff;
  logic [BE_W-1:0]     be_n_ff;
  logic                nxt_multi_n;
  logic [BE_W-1:0]     nxt_be_n;
  logic                rd_pipe_ff;
  logic                nxt_rd_pipe;
  logic [DATA_W-1:0]   dq_data_ff;
  logic [DATA_W-1:0]   nxt_dq_data;
  logic                rdv_ff;
  logic                nxt_rdv;
  logic [DATA_W-1:0]   rdd_ff;
  logic [DATA_W-1:0]   nxt_rdd;
  logic [BE_W-1:0]     rdbe_ff;
  logic [BE_W-1:0]     nxt_rdbe;
  logic                port_hit;
  logic                rd_hit;
  logic                wr_hit;
  logic                phase_done;
  logic                push_allow;
  logic                fifo_in_ready;
  logic                head_valid;
  logic [ENT_W-1:0]    head;
  logic                ahead_valid;
  logic [ENT_W-1:0]    ahead;
  logic [BE_W-1:0]     ahead_be_n;
  logic                ahead_last;
  logic                head_last;
  logic [BE_W-1:0]     done_now;

  // ----------------------------------------------------------------
  // phase queue from the pci side
  // ----------------------------------------------------------------
  // with write fifo off, no posting: a queued word blocks the next one until it drains
  assign push_allow   = WFIFO_BURST_EN || !head_valid;
  assign PCI_PH_READY = fifo_in_ready && push_allow;

  ptpa_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (CLOCK),
    .rst_b     (RST_B),
    .in_valid  (PCI_PH_VALID && push_allow),
    .in_ready  (fifo_in_ready),
    .in_data   ({PCI_PH_LAST, PCI_PH_BE_N, PCI_PH_DATA}),
    .out_valid (head_valid),
    .out_ready (phase_done),
    .out_data    (head),
    .ahead_valid (ahead_valid),
    .ahead_data  (ahead)
  );

  assign ahead_be_n = ahead[ENT_BE_LSB +: BE_W];
  assign ahead_last = ahead[ENT_LAST_BIT];
  assign head_last = head[ENT_LAST_BIT];

  // ----------------------------------------------------------------
  // access sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    port_hit   = !SELECT_N && (ADR == PORT_SEL) &&
                 (PORT_BYTE_ENABLES_N != BE_NONE_N);
    rd_hit     = port_hit && !RD_N;
    wr_hit     = port_hit && !WR_N && CAPTURE_ADDR_STROBE_N;
    phase_done = (state_ff == PTPA_PEND) && !ADDON_READY_N &&
                 head_valid;
    done_now   = done_ff;
    if ((state_ff == PTPA_PEND) && ((write_ff && rd_hit) ||
        (!write_ff && wr_hit)))
    begin
      done_now = done_ff | ~PORT_BYTE_ENABLES_N;
    end
    nxt_state                = state_ff;
    nxt_captured_address_reg = captured_address_reg_ff;
    nxt_region               = region_ff;
    nxt_write                = write_ff;
    nxt_burst                = burst_ff;
    nxt_done                 = done_now;
    case (state_ff)
      PTPA_IDLE:
      begin
        nxt_done = BE_NONE_DONE;
        if (PCI_HIT)
        begin
          nxt_state                = PTPA_PEND;
          nxt_captured_address_reg = PCI_ADDR;
          nxt_region               = PCI_REGION;
          nxt_write                = PCI_WRITE;
          nxt_burst = PCI_BURST && !(PCI_WRITE && !WFIFO_BURST_EN);
        end
      end
      PTPA_PEND:
      begin
        if (phase_done)
        begin
          nxt_done = BE_NONE_DONE;
          nxt_captured_address_reg = {captured_address_reg_ff[31:2] +
                                      ADDR_WORD_STEP, 2'b00};
          if (head_last)
          begin
            nxt_state = PTPA_IDLE;
          end
        end
      end
      default:
      begin
        nxt_state = PTPA_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_ff                <= PTPA_IDLE;
      captured_address_reg_ff <= ADDR_RST;
      region_ff               <= REGION_RST;
      write_ff                <= 1'b0;
      burst_ff                <= 1'b0;
      done_ff                 <= BE_NONE_DONE;
    end
    else
    begin
      state_ff                <= nxt_state;
      captured_address_reg_ff <= nxt_captured_address_reg;
      region_ff               <= nxt_region;
      write_ff                <= nxt_write;
      burst_ff                <= nxt_burst;
      done_ff                 <= nxt_done;
    end
  end

  // ----------------------------------------------------------------
  // status outputs toward the add-on
  // ----------------------------------------------------------------
  // follows the head after this edge, so a completing ready shows the next
  always_comb
  begin
    nxt_multi_n = 1'b1;
    nxt_be_n    = BE_NONE_N;
    if (nxt_state == PTPA_PEND)
    begin
      // no entry queued yet: hold enables until one lands
      nxt_be_n    = be_n_ff;
      nxt_multi_n = multi_n_ff;
      if (ahead_valid)
      begin
        nxt_be_n    = ahead_be_n | nxt_done;
        nxt_multi_n = !(nxt_burst && !ahead_last);
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pend_n_ff  <= 1'b1;
      multi_n_ff <= 1'b1;
      be_n_ff    <= BE_NONE_N;
    end
    else
    begin
      pend_n_ff  <= (nxt_state != PTPA_PEND);
      multi_n_ff <= nxt_multi_n;
      be_n_ff    <= nxt_be_n;
    end
  end

  assign ACCESS_PENDING_N       = pend_n_ff;
  assign MULTI_PHASE_N          = multi_n_ff;
  assign REGION_NUMBER          = region_ff;
  assign DIRECTION_IS_WRITE     = write_ff;
  assign PENDING_BYTE_ENABLES_N = be_n_ff;
  assign PCI_BUSY               = (state_ff == PTPA_PEND);

  // ----------------------------------------------------------------
  // data bus and read-fifo capture
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_rd_pipe = rd_hit;
    nxt_dq_data = rd_hit ? head[ENT_DATA_LSB +: DATA_W] : dq_data_ff;
    nxt_rdv     = (state_ff == PTPA_PEND) && !write_ff && wr_hit;
    nxt_rdd     = nxt_rdv ? DQ_IN : rdd_ff;
    nxt_rdbe    = nxt_rdv ? PORT_BYTE_ENABLES_N : rdbe_ff;
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rd_pipe_ff <= 1'b0;
      dq_data_ff <= DATA_RST;
      rdv_ff     <= 1'b0;
      rdd_ff     <= DATA_RST;
      rdbe_ff    <= BE_NONE_N;
    end
    else
    begin
      rd_pipe_ff <= nxt_rd_pipe;
      dq_data_ff <= nxt_dq_data;
      rdv_ff     <= nxt_rdv;
      rdd_ff     <= nxt_rdd;
      rdbe_ff    <= nxt_rdbe;
    end
  end

  // address strobe is unpipelined, so it overrides the read pipe
  assign DQ_OUT = !CAPTURE_ADDR_STROBE_N ? captured_address_reg_ff
                                         : dq_data_ff;
  assign DQ_OE  = !CAPTURE_ADDR_STROBE_N || rd_pipe_ff;

  assign PCI_RD_VALID = rdv_ff;
  assign PCI_RD_DATA  = rdd_ff;
  assign PCI_RD_BE_N  = rdbe_ff;
endmodule
`default_nettype wire

/* File: ptpa_pkg.sv */
// constants and types shared by the pass-through add-on port
`default_nettype none
package ptpa_pkg;
  // ----------------------------------------------------------------
  // data port decode
  // ----------------------------------------------------------------
  localparam logic [7:0]  PASSTHRU_DATA_PORT_OFS = 8'h2c;
  localparam int          PORT_ADR_LSB           = 2;
  localparam int          PORT_ADR_MSB           = 6;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int          DATA_W                 = 32;
  localparam int          BE_W                   = 4;
  localparam int          REGION_W               = 2;
  localparam int          FIFO_DEPTH             = 4;
  // phase entry layout: {last, byte enables, data}
  localparam int          ENT_DATA_LSB           = 0;
  localparam int          ENT_BE_LSB             = DATA_W;
  localparam int          ENT_LAST_BIT           = DATA_W + BE_W;
  localparam int          ENT_W                  = DATA_W + BE_W + 1;
  // ----------------------------------------------------------------
  // reset values and steps
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_RST               = 32'h0000_0000;
  localparam logic [29:0] ADDR_WORD_STEP         = 30'h0000_0001;
  localparam logic [3:0]  BE_NONE_N              = 4'hf;
  localparam logic [3:0]  BE_NONE_DONE           = 4'h0;
  localparam logic [1:0]  REGION_RST             = 2'h0;
  localparam logic [31:0] DATA_RST               = 32'h0000_0000;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic {PTPA_IDLE, PTPA_PEND} ptpa_state_t;
endpackage
`default_nettype wire

/* File: ptpa_port_sva.sv */
// assertion checker for the pass-through add-on port
`timescale 1ns/100ps
`default_nettype none
module ptpa_port_sva
  import ptpa_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  input wire logic                CLOCK,
  input wire logic                RST_B,
  input wire logic                PCI_HIT,
  input wire logic                PCI_WRITE,
  input wire logic [REGION_W-1:0] PCI_REGION,
  input wire logic                WFIFO_BURST_EN,
  input wire logic                PCI_BUSY,
  input wire logic                PCI_RD_VALID,
  input wire logic [DATA_W-1:0]   PCI_RD_DATA,
  input wire logic                SELECT_N,
  input wire logic [PORT_ADR_MSB:PORT_ADR_LSB] ADR,
  input wire logic [BE_W-1:0]     PORT_BYTE_ENABLES_N,
  input wire logic                RD_N,
  input wire logic                WR_N,
  input wire logic                CAPTURE_ADDR_STROBE_N,
  input wire logic                ADDON_READY_N,
  input wire logic [DATA_W-1:0]   DQ_IN,
  input wire logic                DQ_OE,
  input wire logic                ACCESS_PENDING_N,
  input wire logic                MULTI_PHASE_N,
  input wire logic [REGION_W-1:0] REGION_NUMBER,
  input wire logic                DIRECTION_IS_WRITE
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  logic port_hit;
  assign port_hit = !SELECT_N && (PORT_BYTE_ENABLES_N != BE_NONE_N) &&
    (ADR == PASSTHRU_DATA_PORT_OFS[PORT_ADR_MSB:PORT_ADR_LSB]);
  sequence s_hit;
    PCI_HIT && !PCI_BUSY;
  endsequence
  sequence s_rd;
    port_hit && !RD_N;
  endsequence
  sequence s_wr;
    port_hit && !WR_N && CAPTURE_ADDR_STROBE_N && !ACCESS_PENDING_N
      && !DIRECTION_IS_WRITE;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  hit_pending_a: assert property (s_hit |=> !ACCESS_PENDING_N && PCI_BUSY)
    else $error("pending flag not set after hit");
  hit_status_a: assert property (s_hit |=> REGION_NUMBER == $past(PCI_REGION)
    && DIRECTION_IS_WRITE == $past(PCI_WRITE))
    else $error("region or direction wrong after hit");
  addr_drive_a: assert property (!CAPTURE_ADDR_STROBE_N |-> DQ_OE)
    else $error("address strobe does not drive bus");
  rd_pipe_a: assert property (s_rd |=> DQ_OE)
    else $error("pipelined read does not drive bus");
  bus_float_a: assert property (!(port_hit && !RD_N)
    |=> (CAPTURE_ADDR_STROBE_N -> !DQ_OE))
    else $error("bus driven without a cause");
  wr_capture_a: assert property (s_wr |=> PCI_RD_VALID
    && PCI_RD_DATA == $past(DQ_IN))
    else $error("port write not captured");
  rdy_wait_a: assert property (!ACCESS_PENDING_N && ADDON_READY_N
    |=> !ACCESS_PENDING_N)
    else $error("access ended without ready");
  single_burst_a: assert property (!WFIFO_BURST_EN && DIRECTION_IS_WRITE
    && !ACCESS_PENDING_N |-> MULTI_PHASE_N)
    else $error("burst flag with write fifo off");
endmodule
bind ptpa_port ptpa_port_sva #(.DEPTH(DEPTH)) u_sva (.CLOCK(CLOCK),
  .RST_B(RST_B), .PCI_HIT(PCI_HIT), .PCI_WRITE(PCI_WRITE),
  .PCI_REGION(PCI_REGION), .WFIFO_BURST_EN(WFIFO_BURST_EN),
  .PCI_BUSY(PCI_BUSY), .PCI_RD_VALID(PCI_RD_VALID),
  .PCI_RD_DATA(PCI_RD_DATA), .SELECT_N(SELECT_N), .ADR(ADR),
  .PORT_BYTE_ENABLES_N(PORT_BYTE_ENABLES_N), .RD_N(RD_N), .WR_N(WR_N),
  .CAPTURE_ADDR_STROBE_N(CAPTURE_ADDR_STROBE_N),
  .ADDON_READY_N(ADDON_READY_N), .DQ_IN(DQ_IN), .DQ_OE(DQ_OE),
  .ACCESS_PENDING_N(ACCESS_PENDING_N), .MULTI_PHASE_N(MULTI_PHASE_N),
  .REGION_NUMBER(REGION_NUMBER), .DIRECTION_IS_WRITE(DIRECTION_IS_WRITE));
`default_nettype wire

/* File: ptpa_addon.sv */
// behavioural add-on logic facing the pass-through port
`timescale 1ns/100ps
`default_nettype none
module ptpa_addon
  import ptpa_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] dq,
  output var  logic              sel_n,
  output var  logic [4:0]        adr,
  output var  logic [BE_W-1:0]   be_n,
  output var  logic              rd_n,
  output var  logic              wr_n,
  output var  logic              strobe_n,
  output var  logic              rdy_n,
  output var  logic [DATA_W-1:0] dq_drv
);
  // all changes at the falling edge, synchronous to the clock
  initial
  begin
    sel_n = 1; adr = 5'h00; be_n = 4'hf; rd_n = 1; wr_n = 1;
    strobe_n = 1; rdy_n = 1; dq_drv = 32'h0;
  end
  // address read, then one turn-around clock; never with write strobe
  task automatic get_addr(output logic [31:0] a);
    @(negedge clk);
    strobe_n = 0;
    @(posedge clk);
    a = dq;
    @(negedge clk);
    strobe_n = 1;
    @(negedge clk);
  endtask
  // one data phase with ready; call at a falling edge, returns at one
  task automatic move(input logic wr, input logic [31:0] d,
                      output logic [31:0] q);
    sel_n = 0; adr = 5'h0b; be_n = 4'h0; rdy_n = 0;
    rd_n = wr;
    wr_n = !wr;
    dq_drv = d;
    @(posedge clk);
    @(negedge clk);
    q = dq;
  endtask
  // read strobe through a wait state, ready held off; upper bytes only
  task automatic peek(output logic [31:0] q);
    sel_n = 0; adr = 5'h0b; be_n = 4'h3; rdy_n = 1; rd_n = 0; wr_n = 1;
    @(posedge clk);
    @(negedge clk);
    q = dq;
  endtask
  // release after a data phase; data lines show no stale word
  task automatic idle();
    sel_n = 1; adr = 5'h00; be_n = 4'hf; rd_n = 1; wr_n = 1; rdy_n = 1;
    dq_drv = ~dq_drv;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// testbench for the pass-through add-on port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ptpa_pkg::*;
  logic clk, rst_b, hit, wr, burst, wfen, ph_valid, ph_last;
  logic [1:0] region;
  logic [31:0] addr, ph_data, q;
  logic [3:0] ph_be;
  wire logic busy, ph_ready, rd_valid, oe, sel_n, rd_n, wr_n, stb_n, rdy_n;
  wire logic pend_n, multi_n, dir;
  wire logic [31:0] rd_data, dq_out, dq_drv, dq;
  wire logic [3:0] rd_be, be_n, pbe_n;
  wire logic [1:0] reg_num;
  wire logic [4:0] adr;
  int fail_count = 0;
  int checked = 0;
  assign dq = oe ? dq_out : dq_drv;
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  ptpa_port #(.DEPTH(4)) u_dut (.CLOCK(clk), .RST_B(rst_b), .PCI_HIT(hit),
    .PCI_WRITE(wr), .PCI_BURST(burst), .PCI_REGION(region), .PCI_ADDR(addr),
    .WFIFO_BURST_EN(wfen), .PCI_BUSY(busy), .PCI_PH_VALID(ph_valid),
    .PCI_PH_READY(ph_ready), .PCI_PH_DATA(ph_data), .PCI_PH_BE_N(ph_be),
    .PCI_PH_LAST(ph_last), .PCI_RD_VALID(rd_valid), .PCI_RD_DATA(rd_data),
    .PCI_RD_BE_N(rd_be), .SELECT_N(sel_n), .ADR(adr),
    .PORT_BYTE_ENABLES_N(pbe_n), .RD_N(rd_n), .WR_N(wr_n),
    .CAPTURE_ADDR_STROBE_N(stb_n), .ADDON_READY_N(rdy_n), .DQ_IN(dq),
    .DQ_OUT(dq_out), .DQ_OE(oe), .ACCESS_PENDING_N(pend_n),
    .MULTI_PHASE_N(multi_n), .REGION_NUMBER(reg_num),
    .DIRECTION_IS_WRITE(dir), .PENDING_BYTE_ENABLES_N(be_n));
  ptpa_addon u_addon (.clk(clk), .dq(dq), .sel_n(sel_n), .adr(adr),
    .be_n(pbe_n), .rd_n(rd_n), .wr_n(wr_n), .strobe_n(stb_n),
    .rdy_n(rdy_n), .dq_drv(dq_drv));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // push one phase entry, waiting on ready before the edge
  task automatic push(input logic [31:0] d, input logic [3:0] be,
                      input logic last);
    int n;
    n = 0;
    ph_valid = 1; ph_data = d; ph_be = be; ph_last = last;
    while (ph_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    @(negedge clk);
    ph_valid = 0;
    hit = 0;
  endtask
  // region hit with its first entry, then wait for pending and status
  task automatic access(input logic w, input logic b, input logic [1:0] rg,
                        input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] be, input logic last);
    int n;
    n = 0;
    hit = 1; wr = w; burst = b; region = rg; addr = a;
    push(d, be, last);
    while (pend_n !== 1'b0 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_b = 0; hit = 0; wr = 0; burst = 0; region = 2'h0; addr = 32'h0;
    wfen = 1; ph_valid = 0; ph_data = 32'h0; ph_be = 4'h0; ph_last = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_b = 1;
    chk("idle flags", 4'hc, {pend_n, multi_n, reg_num});
    chk("idle be", 4'hf, be_n);
    // single write, region 1, all bytes
    access(1, 0, 2'h1, 32'h1000_0040, 32'h1234_5678, 4'h0, 1);
    chk("status", 5'h0b, {pend_n, multi_n, reg_num, dir});
    chk("be", 4'h0, be_n);
    u_addon.get_addr(q);
    chk("addr", 32'h1000_0040, q);
    u_addon.move(0, 32'h0, q);
    u_addon.idle();
    chk("wdata", 32'h1234_5678, q);
    chk("done", 1'b1, pend_n);
    // single read, region 2, with a held-off ready
    access(0, 0, 2'h2, 32'h2000_0080, 32'h0, 4'h0, 1);
    chk("rstatus", 5'h0c, {pend_n, multi_n, reg_num, dir});
    repeat (3) @(negedge clk);
    chk("held", 1'b0, pend_n);
    u_addon.move(1, 32'hcafe_0123, q);
    u_addon.idle();
    chk("rvalid", 1'b1, rd_valid);
    chk("rdata", 32'hcafe_0123, rd_data);
    chk("rbe", 4'h0, rd_be);
    chk("rdone", 1'b1, pend_n);
    // burst write of three words, ready held
    access(1, 1, 2'h3, 32'h3000_0100, 32'ha000_0001, 4'h0, 0);
    push(32'ha000_0002, 4'h3, 0);
    push(32'ha000_0003, 4'hc, 1);
    chk("burst", 1'b0, multi_n);
    u_addon.peek(q);
    chk("early data", 32'ha000_0001, q);
    chk("early be", 4'hc, be_n);
    u_addon.move(0, 32'h0, q);
    chk("b1", 32'ha000_0001, q);
    chk("be2", 4'h3, be_n);
    u_addon.move(0, 32'h0, q);
    chk("b2", 32'ha000_0002, q);
    chk("last flag", 1'b1, multi_n);
    chk("still pending", 1'b0, pend_n);
    chk("be3", 4'hc, be_n);
    u_addon.move(0, 32'h0, q);
    u_addon.idle();
    chk("b3", 32'ha000_0003, q);
    chk("bdone", 1'b1, pend_n);
    u_addon.get_addr(q);
    chk("advance", 32'h3000_010c, q);
    // write fifo off: one word at a time, no burst flag
    wfen = 0;
    access(1, 1, 2'h0, 32'h0, 32'hb000_0001, 4'h0, 0);
    chk("one word", 1'b0, ph_ready);
    chk("no burst", 1'b1, multi_n);
    u_addon.move(0, 32'h0, q);
    u_addon.idle();
    chk("w1", 32'hb000_0001, q);
    push(32'hb000_0002, 4'h0, 1);
    u_addon.move(0, 32'h0, q);
    u_addon.idle();
    chk("w2", 32'hb000_0002, q);
    chk("wdone", 1'b1, pend_n);
    end_of_test();
  end
  // hang guard, far beyond the few dozen cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
